// *** logic/blf_pkg.sv ***
// Package for the backlight fade and level current register bank.
// Assumes one 200 MHz system clock and a byte-wide register port.
package blf_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] BLF_ADDR_FADE = 8'h04; // Fade-in and fade-out timers
  localparam logic [7:0] BLF_ADDR_DAY_MAX = 8'h05; // Bright ambient full current
  localparam logic [7:0] BLF_ADDR_DAY_DIM = 8'h06; // Bright ambient dimmed current
  localparam logic [7:0] BLF_ADDR_OFF_MAX = 8'h07; // Indoor full current
  localparam logic [7:0] BLF_ADDR_OFF_DIM = 8'h08; // Indoor dimmed current
  localparam logic [7:0] BLF_ADDR_VALUE = 8'h0b; // Present sink code, read only

  // ==========================================================
  // Field layout and reset values
  localparam int BLF_FO_MSB = 7; // Fade-out nibble
  localparam int BLF_FO_LSB = 4;
  localparam int BLF_FI_MSB = 3; // Fade-in nibble
  localparam int BLF_FI_LSB = 0;
  localparam int BLF_CODE_W = 7; // Sink code width
  localparam logic [7:0] BLF_FADE_RST = 8'h00;
  localparam logic [6:0] BLF_CODE_RST = 7'h00;
  localparam logic [3:0] BLF_FADE_OFF = 4'h0; // Fading disabled
  localparam logic [3:0] BLF_FADE_KNEE = 4'ha; // Last code of the 0.3 s steps

  // ==========================================================
  // Ambient level selection codes
  typedef enum logic [1:0] {
    BLF_LVL_DAY = 2'b00,
    BLF_LVL_OFFICE = 2'b01,
    BLF_LVL_DARK = 2'b10
  } blf_level_t;

  // ==========================================================
  // Timing: fade durations counted in tenths of a second
  localparam int BLF_CLK_MHZ = 200; // System clock rate
  localparam int BLF_TENTH_MS = 100; // One fade unit in ms
  localparam int BLF_STEPS = 128; // Sink code steps across full scale
  localparam int BLF_STEP_BASE_CYC = BLF_TENTH_MS * 1000 * BLF_CLK_MHZ / BLF_STEPS;
  localparam logic [5:0] BLF_SMALL_STEP = 6'h03; // 0.3 s per code up to 3.0 s
  localparam logic [5:0] BLF_LARGE_STEP = 6'h05; // 0.5 s per code above
  localparam logic [5:0] BLF_KNEE_TENTHS = 6'h1e; // 3.0 s

  // ==========================================================
  // Host register access carrier
  typedef struct packed {
    logic wr; // Write strobe, one cycle
    logic rd; // Read strobe, one cycle
    logic [7:0] addr; // Register offset
    logic [7:0] wdata; // Write data
  } blf_req_t;

endpackage : blf_pkg

// *** logic/blf_regs.sv ***
// Backlight fade timers, level current registers and the sink code ramp.
// Assumes the serial host interface delivers decoded byte strobes on clk_sys.
//
// Behaviour
// - Fade-out time lives in upper fade nibble
// - Fade-in time lives in lower fade nibble
// - Daylight full current code at 0x05
// - Daylight dimmed current code at 0x06
// - Office full current code at 0x07
// - Office dimmed current code at 0x08
// - Level select picks daylight, office or dark
// - Present sink code readable, tracks fades
module blf_regs
  import blf_pkg::*;
#(
  parameter int STEP_BASE_CYC = BLF_STEP_BASE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire blf_req_t host_req,
  output logic [7:0] host_rdata,
  input wire logic backlight_on,
  input wire logic [1:0] ambient_level_select,
  input wire logic dim_request,
  input wire logic [6:0] dark_full_code,
  input wire logic [6:0] dark_dim_code,
  output logic [6:0] present_sink_code,
  output logic fade_active
);

  // ==========================================================
  // Reset release
  logic rst_q1; // First synchroniser stage
  logic rst_s_n; // Released reset used by the block

  // Two stages so release is clean against clk_sys
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_s_n <= rst_q1;
    end
  end

  // ==========================================================
  // Helpers
  // Fade code to duration in tenths of a second
  function automatic logic [5:0] fade_tenths(input logic [3:0] code);
    logic [5:0] c;
    c = {2'b00, code};
    if (code <= BLF_FADE_KNEE) begin
      fade_tenths = 6'(c * BLF_SMALL_STEP);
    end else begin
      fade_tenths = 6'(BLF_KNEE_TENTHS + (c - 6'(BLF_FADE_KNEE)) * BLF_LARGE_STEP);
    end
  endfunction : fade_tenths

  // ==========================================================
  // Register storage
  logic [7:0] fade_timers; // Fade-out high, fade-in low
  logic [6:0] day_max; // Daylight full code
  logic [6:0] day_dim; // Daylight dimmed code
  logic [6:0] off_max; // Office full code
  logic [6:0] off_dim; // Office dimmed code

  // Write decode
  wire wr_fade = host_req.wr && (host_req.addr == BLF_ADDR_FADE);
  wire wr_dmax = host_req.wr && (host_req.addr == BLF_ADDR_DAY_MAX);
  wire wr_ddim = host_req.wr && (host_req.addr == BLF_ADDR_DAY_DIM);
  wire wr_omax = host_req.wr && (host_req.addr == BLF_ADDR_OFF_MAX);
  wire wr_odim = host_req.wr && (host_req.addr == BLF_ADDR_OFF_DIM);
  wire [6:0] wr_code = host_req.wdata[BLF_CODE_W-1:0]; // Bit 7 dropped

  // Store writes; only the low seven bits of current codes are kept
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      fade_timers <= BLF_FADE_RST;
      day_max <= BLF_CODE_RST;
      day_dim <= BLF_CODE_RST;
      off_max <= BLF_CODE_RST;
      off_dim <= BLF_CODE_RST;
    end else begin
      if (wr_fade) fade_timers <= host_req.wdata;
      if (wr_dmax) day_max <= wr_code;
      if (wr_ddim) day_dim <= wr_code;
      if (wr_omax) off_max <= wr_code;
      if (wr_odim) off_dim <= wr_code;
    end
  end

  // ==========================================================
  // Read path, unused bits and unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = host_rdata;
    if (host_req.rd) begin
      unique case (host_req.addr)
        BLF_ADDR_FADE: next_rdata = fade_timers;
        BLF_ADDR_DAY_MAX: next_rdata = {1'b0, day_max};
        BLF_ADDR_DAY_DIM: next_rdata = {1'b0, day_dim};
        BLF_ADDR_OFF_MAX: next_rdata = {1'b0, off_max};
        BLF_ADDR_OFF_DIM: next_rdata = {1'b0, off_dim};
        BLF_ADDR_VALUE: next_rdata = {1'b0, present_sink_code};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Read data register, holds until the next read
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) host_rdata <= 8'h00;
    else host_rdata <= next_rdata;
  end

  // ==========================================================
  // Target selection by ambient level and dim request
  wire [6:0] max_sel = (ambient_level_select == BLF_LVL_DAY) ? day_max :
                       (ambient_level_select == BLF_LVL_OFFICE) ? off_max :
                       dark_full_code;
  wire [6:0] dim_sel = (ambient_level_select == BLF_LVL_DAY) ? day_dim :
                       (ambient_level_select == BLF_LVL_OFFICE) ? off_dim :
                       dark_dim_code;
  wire [6:0] target = !backlight_on ? BLF_CODE_RST : (dim_request ? dim_sel : max_sel);

  // ==========================================================
  // Ramp engine; fade-in when rising, fade-out when falling
  wire rising = target > present_sink_code;
  wire [3:0] fade_code = rising ? fade_timers[BLF_FI_MSB:BLF_FI_LSB] :
                                  fade_timers[BLF_FO_MSB:BLF_FO_LSB];
  wire [29:0] step_period = 30'(fade_tenths(fade_code) * STEP_BASE_CYC);
  wire at_target = (target == present_sink_code);
  logic [29:0] step_cnt; // Cycles since the last code step
  wire step_due = (step_cnt >= step_period - 30'h1);

  // Step counter runs only while a fade is under way
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) step_cnt <= 30'h0;
    else if (at_target || step_due || fade_code == BLF_FADE_OFF) step_cnt <= 30'h0;
    else step_cnt <= step_cnt + 30'h1;
  end

  // Present code: jump when fading is off, one code per period otherwise
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      present_sink_code <= BLF_CODE_RST;
      fade_active <= 1'b0;
    end else begin
      fade_active <= !at_target && (fade_code != BLF_FADE_OFF);
      if (at_target) begin
        present_sink_code <= present_sink_code;
      end else if (fade_code == BLF_FADE_OFF) begin
        present_sink_code <= target;
      end else if (step_due) begin
        present_sink_code <= rising ? present_sink_code + 7'h01 :
                                      present_sink_code - 7'h01;
      end
    end
  end

  // ==========================================================
  // Assertions
  property p_fade_store;
    @(posedge clk_sys) disable iff (!rst_s_n)
      wr_fade |=> fade_timers == $past(host_req.wdata);
  endproperty
  a_fade_store: assert property (p_fade_store) else $error("fade timers not stored");

  property p_fade_readback;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (host_req.rd && host_req.addr == BLF_ADDR_FADE) |=> host_rdata == $past(fade_timers);
  endproperty
  a_fade_readback: assert property (p_fade_readback) else $error("fade readback wrong");

  property p_day_max;
    @(posedge clk_sys) disable iff (!rst_s_n)
      wr_dmax |=> day_max == $past(host_req.wdata[6:0]);
  endproperty
  a_day_max: assert property (p_day_max) else $error("daylight full code wrong");

  property p_day_dim;
    @(posedge clk_sys) disable iff (!rst_s_n)
      wr_ddim |=> day_dim == $past(host_req.wdata[6:0]);
  endproperty
  a_day_dim: assert property (p_day_dim) else $error("daylight dim code wrong");

  property p_off_max;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (host_req.rd && host_req.addr == BLF_ADDR_OFF_MAX) |=> host_rdata == {1'b0, $past(off_max)};
  endproperty
  a_off_max: assert property (p_off_max) else $error("office full readback wrong");

  property p_off_dim;
    @(posedge clk_sys) disable iff (!rst_s_n)
      wr_odim |=> off_dim == $past(host_req.wdata[6:0]);
  endproperty
  a_off_dim: assert property (p_off_dim) else $error("office dim code wrong");

  property p_level_office;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (backlight_on && ambient_level_select == BLF_LVL_OFFICE)
        |-> target == (dim_request ? off_dim : off_max);
  endproperty
  a_level_office: assert property (p_level_office) else $error("office target wrong");

  property p_value_read;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (host_req.rd && host_req.addr == BLF_ADDR_VALUE) |=> host_rdata == {1'b0, $past(present_sink_code)};
  endproperty
  a_value_read: assert property (p_value_read) else $error("present code readback wrong");

  property p_jump;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (!at_target && fade_code == BLF_FADE_OFF) |=> present_sink_code == $past(target);
  endproperty
  a_jump: assert property (p_jump) else $error("no direct step with fading off");

  property p_ramp_step;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (fade_code != BLF_FADE_OFF && !at_target && !step_due) |=> $stable(present_sink_code);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("code moved between steps");

endmodule : blf_regs

// *** tb/blf_regs_test.sv ***
// Testbench for the backlight fade and level current register bank.
// Assumes blf_pkg is compiled first; the bench drives every input itself.
module blf_regs_test import blf_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0; // 200 MHz system clock
  logic rst_n; // Active low reset
  blf_req_t host_req; // Register port request
  logic [7:0] host_rdata;
  logic backlight_on;
  logic [1:0] ambient_level_select;
  logic dim_request;
  logic [6:0] dark_full_code = 7'h31; // Dark codes from outside
  logic [6:0] dark_dim_code = 7'h0e;
  logic [6:0] present_sink_code;
  logic fade_active;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  // Short step base of 2 cycles per tenth keeps each ramp step to between 6 and 110 cycles
  blf_regs #(.STEP_BASE_CYC(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .host_req(host_req),
    .host_rdata(host_rdata), .backlight_on(backlight_on),
    .ambient_level_select(ambient_level_select), .dim_request(dim_request),
    .dark_full_code(dark_full_code), .dark_dim_code(dark_dim_code),
    .present_sink_code(present_sink_code), .fade_active(fade_active));
  // ==========================================================
  // Clock and hang guard
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin // Far beyond the expected run
      err_count++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    host_req.wr = 1'b0;
  endtask : wr_reg
  // Read data is registered, so it is looked at one edge after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    host_req.rd = 1'b0;
    check(host_rdata, exp, "register read");
  endtask : rd_chk
  task automatic set_in(input logic on, input logic [1:0] lvl, input logic dim);
    @(negedge clk_sys);
    backlight_on = on;
    ambient_level_select = lvl;
    dim_request = dim;
  endtask : set_in
  // Waits for the ramp to land and checks how long it took
  task automatic ramp(input logic [6:0] tgt, input int lo, input int hi);
    int n;
    bit seen;
    n = 0;
    seen = 1'b0;
    while (present_sink_code !== tgt && n < 400) begin
      @(negedge clk_sys);
      n++;
      if (fade_active === 1'b1) seen = 1'b1;
    end
    check({1'b0, present_sink_code}, {1'b0, tgt}, "ramp end code");
    check({7'h00, seen}, {7'h00, lo > 3}, "fade active seen");
    compares++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("[ERR] %0t ramp took %0d cycles", $time, n);
    end
  endtask : ramp
  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Main sequence
  logic [7:0] addr_tab[6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b};
  logic [7:0] wd_tab[6] = '{8'ha5, 8'hff, 8'hd5, 8'haa, 8'h93, 8'h7f};
  logic [7:0] rd_tab[6] = '{8'ha5, 8'h7f, 8'h55, 8'h2a, 8'h13, 8'h00};
  logic [6:0] lvl_tab[8] = '{7'h7f, 7'h55, 7'h2a, 7'h13, 7'h31, 7'h0e, 7'h31, 7'h0e};
  initial begin
    host_req = '0;
    rst_n = 1'b0;
    backlight_on = 1'b0;
    ambient_level_select = 2'b00;
    dim_request = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    // Reset values, unmapped offset reads zero
    foreach (addr_tab[i]) rd_chk(addr_tab[i], 8'h00);
    rd_chk(8'h09, 8'h00);
    $display("Test reset values done");
    // Write and read back; bit 7 dropped, read-only code ignores writes
    foreach (addr_tab[i]) wr_reg(addr_tab[i], wd_tab[i]);
    foreach (addr_tab[i]) rd_chk(addr_tab[i], rd_tab[i]);
    $display("Test register access done");
    // Fading off: every level and dim choice steps straight to its code
    wr_reg(8'h04, 8'h00);
    for (int i = 0; i < 8; i++) begin
      set_in(1'b1, i[2:1], i[0]);
      @(negedge clk_sys);
      check({1'b0, present_sink_code}, {1'b0, lvl_tab[i]}, "level code");
      check({7'h00, fade_active}, 8'h00, "no fade");
      rd_chk(8'h0b, {1'b0, lvl_tab[i]});
    end
    $display("Test level selection done");
    // Ramps: fade-in 0.3 s is 6 cycles a step, fade-out 0.6 s is 12
    set_in(1'b0, 2'b00, 1'b0);
    ramp(7'h00, 0, 3);
    wr_reg(8'h05, 8'h05);
    wr_reg(8'h04, 8'h21);
    set_in(1'b1, 2'b00, 1'b0);
    ramp(7'h05, 24, 36);
    rd_chk(8'h0b, 8'h05);
    set_in(1'b0, 2'b00, 1'b0);
    ramp(7'h00, 50, 70);
    // Above the knee: code f is 5.5 s, code b is 3.5 s per step
    wr_reg(8'h05, 8'h01);
    wr_reg(8'h04, 8'h0f);
    set_in(1'b1, 2'b00, 1'b0);
    ramp(7'h01, 100, 120);
    set_in(1'b0, 2'b00, 1'b0);
    ramp(7'h00, 0, 3);
    wr_reg(8'h04, 8'h0b);
    set_in(1'b1, 2'b00, 1'b0);
    ramp(7'h01, 60, 80);
    $display("Test ramps done");
    end_of_test();
  end
endmodule : blf_regs_test
